// ==== include/clk_pkg.sv ====
// Shared constants for the clock distribution device and its controller.
// Assumes both ends and the link run on the one system clock.
package clk_pkg;
  localparam int NCH = 4;
  localparam int NPAIR = 2;
  // Device register addresses
  localparam logic [7:0] A_GLOBAL = 8'h01;
  localparam logic [7:0] A_GPO_SEL = 8'h46;
  localparam logic [7:0] A_PULSE_CNT = 8'h5A;
  localparam logic [7:0] A_TMR_LO = 8'h5C;
  localparam logic [7:0] A_TMR_HI = 8'h5D;
  localparam logic [7:0] A_STATUS = 8'h7D;
  localparam logic [7:0] A_UPDATE = 8'h9F;
  localparam logic [7:0] A_CH_BASE = 8'hC8;
  // Bit positions
  localparam int G_RESEED = 0;
  localparam int G_RESTART = 1;
  localparam int G_PULSE = 2;
  localparam int ST_VALID = 2;
  localparam int ST_PHASE = 3;
  localparam int CH_EN = 0;
  localparam int CH_SYNC = 1;
  localparam int CH_PMODE = 2;
  // Arbitrary neutral value for the configuration update register
  localparam logic [7:0] UPDATE_VAL = 8'h5A;
  localparam logic [11:0] TMR_RST = 12'h004;
  localparam logic [7:0] PCNT_RST = 8'h04;
  localparam logic [7:0] CH_RST = 8'h10;
  // Counts in reference timer periods
  localparam logic [4:0] CAL_TICKS = 5'd2;
  localparam logic [4:0] PHASE_TICKS = 5'd6;
  localparam logic [4:0] PULSE_GAP_TICKS = 5'd20;
  // Counts in system clock cycles
  localparam logic [19:0] RST_HOLD = 20'h00004;
  localparam logic [19:0] POLL_TIMEOUT = 20'h00FA0;
  // Controller register offsets on AHB-Lite
  localparam logic [7:0] R_CTRL = 8'h00;
  localparam logic [7:0] R_CFG = 8'h04;
  localparam logic [7:0] R_PULSE = 8'h08;
  localparam logic [7:0] R_STATUS = 8'h0C;
  localparam logic [7:0] R_IRQ_ST = 8'h10;
  localparam logic [7:0] R_IRQ_MASK = 8'h14;
  localparam logic [31:0] CFG_RST = 32'h10030004;
  // Controller program steps
  typedef enum logic [2:0] {
    K_WR = 3'b000,
    K_RST = 3'b001,
    K_WAIT = 3'b010,
    K_POLL = 3'b011,
    K_END = 3'b100
  } kind_t;
  typedef struct packed {
    kind_t kind;
    logic [7:0] addr;
    logic [7:0] data;
  } step_t;
endpackage

// ==== include/clk_link_if.sv ====
// Control link between controller and clock distribution device.
// Synchronous to the shared system clock; joined by the testbench.
`timescale 1ns/1ps
interface clk_link_if;
  logic dev_rst;
  logic wr;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic general_output_pin;
  modport dev(input dev_rst, wr, addr, wdata, output rdata, general_output_pin);
  modport ctl(output dev_rst, wr, addr, wdata, input rdata, general_output_pin);
endinterface

// ==== verilog/clk_dist_dev.sv ====
// Clock distribution device: register file, reference timer, restart,
// sync and pulse generator sequencing for paired output channels.
// Assumes the link is synchronous to CLK_I; INPUT_CLOCK_PIN_OK_I is asynchronous.
`timescale 1ns/1ps
module clk_dist_dev (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic INPUT_CLOCK_PIN_OK_I,
  clk_link_if.dev link,
  output logic [clk_pkg::NCH-1:0] CH_OUT_O,
  output logic REF_VALID_O
);
  import clk_pkg::*;
  logic [7:0] update_reg, pcnt_reg, gpo_sel_reg;
  logic [11:0] tmr_reg;
  logic [2:0] glob_reg, glob_prev_reg;
  logic [7:0] ch_reg [NCH];
  logic ok_m_reg, ok_reg;
  logic [11:0] tcnt_reg;
  logic tick;
  logic [4:0] cal_reg, phase_reg;
  logic calib_reg, phase_ok_reg, sync_reg;
  logic [NPAIR-1:0] pair_sync_reg;
  logic [8:0] pleft_reg;
  logic plvl_reg;
  logic [3:0] dcnt_reg [NCH];
  logic valid;
  logic [7:0] rdata_reg;
  logic restart_fall, reseed_rise, pulse_rise;

  assign restart_fall = glob_prev_reg[G_RESTART] & ~glob_reg[G_RESTART];
  assign reseed_rise = glob_reg[G_RESEED] & ~glob_prev_reg[G_RESEED];
  assign pulse_rise = glob_reg[G_PULSE] & ~glob_prev_reg[G_PULSE];
  assign tick = (tcnt_reg == 12'h000);
  assign valid = calib_reg & phase_ok_reg & ok_reg;

  // Input clock presence is asynchronous
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ok_m_reg <= 1'b0;
      ok_reg <= 1'b0;
    end else begin
      ok_m_reg <= INPUT_CLOCK_PIN_OK_I;
      ok_reg <= ok_m_reg;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      update_reg <= 8'h00;
      tmr_reg <= TMR_RST;
      pcnt_reg <= PCNT_RST;
      gpo_sel_reg <= 8'h00;
      glob_reg <= 3'h0;
      for (int i = 0; i < NCH; i++) ch_reg[i] <= CH_RST;
    end else if (link.dev_rst) begin
      update_reg <= 8'h00;
      tmr_reg <= TMR_RST;
      pcnt_reg <= PCNT_RST;
      gpo_sel_reg <= 8'h00;
      glob_reg <= 3'h0;
      for (int i = 0; i < NCH; i++) ch_reg[i] <= CH_RST;
    end else if (link.wr) begin
      if (link.addr == A_UPDATE) begin
        update_reg <= link.wdata;
      end else if (link.addr == A_TMR_LO) begin
        tmr_reg[7:0] <= link.wdata;
      end else if (link.addr == A_TMR_HI) begin
        tmr_reg[11:8] <= link.wdata[3:0];
      end else if (link.addr == A_PULSE_CNT) begin
        pcnt_reg <= link.wdata;
      end else if (link.addr == A_GPO_SEL) begin
        gpo_sel_reg <= link.wdata;
      end else if (link.addr == A_GLOBAL) begin
        glob_reg <= link.wdata[2:0];
      end else if (link.addr[7:2] == A_CH_BASE[7:2]) begin
        ch_reg[link.addr[1:0]] <= link.wdata;
      end
    end
  end

  // Reference timer; a setting of zero behaves as one
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      tcnt_reg <= 12'h000;
      glob_prev_reg <= 3'h0;
    end else begin
      glob_prev_reg <= glob_reg;
      if (!ok_reg || glob_reg[G_RESTART] || tick) begin
        tcnt_reg <= (tmr_reg == 12'h000) ? 12'h000 : tmr_reg - 12'h001;
      end else begin
        tcnt_reg <= tcnt_reg - 12'h001;
      end
    end
  end

  // Restart holds the dividers, release starts calibration
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      calib_reg <= 1'b0;
      cal_reg <= 5'd0;
    end else if (link.dev_rst || glob_reg[G_RESTART] || !ok_reg) begin
      calib_reg <= 1'b0;
      cal_reg <= 5'd0;
    end else if (restart_fall) begin
      cal_reg <= CAL_TICKS;
    end else if (tick && cal_reg != 5'd0) begin
      cal_reg <= cal_reg - 5'd1;
      calib_reg <= (cal_reg == 5'd1);
    end
  end

  // Sync request, retimed once per channel pair
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      sync_reg <= 1'b0;
      pair_sync_reg <= '0;
      phase_reg <= 5'd0;
      phase_ok_reg <= 1'b0;
    end else begin
      sync_reg <= reseed_rise & calib_reg;
      pair_sync_reg <= {NPAIR{sync_reg}};
      if (!calib_reg) begin
        phase_ok_reg <= 1'b0;
        phase_reg <= 5'd0;
      end else if (sync_reg) begin
        phase_ok_reg <= 1'b0;
        phase_reg <= PHASE_TICKS;
      end else if (tick && phase_reg != 5'd0) begin
        phase_reg <= phase_reg - 5'd1;
        phase_ok_reg <= (phase_reg == 5'd1);
      end
    end
  end

  // Pulse chain: one timer period high, one low, per pulse
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      pleft_reg <= 9'd0;
      plvl_reg <= 1'b0;
    end else if (!calib_reg) begin
      pleft_reg <= 9'd0;
      plvl_reg <= 1'b0;
    end else if (sync_reg || pulse_rise) begin
      pleft_reg <= {pcnt_reg, 1'b0};
      plvl_reg <= 1'b0;
    end else if (tick && pleft_reg != 9'd0) begin
      pleft_reg <= pleft_reg - 9'd1;
      plvl_reg <= ~plvl_reg;
    end
  end

  // Dividers; field [7:4] is the half period minus one
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      CH_OUT_O <= '0;
      for (int i = 0; i < NCH; i++) dcnt_reg[i] <= 4'h0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (!calib_reg || !ch_reg[i][CH_EN]) begin
          dcnt_reg[i] <= 4'h0;
          CH_OUT_O[i] <= 1'b0;
        end else if (pair_sync_reg[i/2] && ch_reg[i][CH_SYNC]) begin
          dcnt_reg[i] <= 4'h0;
          CH_OUT_O[i] <= 1'b0;
        end else if (ch_reg[i][CH_PMODE]) begin
          CH_OUT_O[i] <= plvl_reg;
        end else if (dcnt_reg[i] == ch_reg[i][7:4]) begin
          dcnt_reg[i] <= 4'h0;
          CH_OUT_O[i] <= ~CH_OUT_O[i];
        end else begin
          dcnt_reg[i] <= dcnt_reg[i] + 4'h1;
        end
      end
    end
  end

  // Read data one cycle after the address
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rdata_reg <= 8'h00;
      link.general_output_pin <= 1'b0;
      REF_VALID_O <= 1'b0;
    end else begin
      link.general_output_pin <= gpo_sel_reg[0] & valid;
      REF_VALID_O <= valid;
      if (link.addr == A_STATUS) begin
        rdata_reg <= {4'h0, phase_ok_reg, valid, 2'b00};
      end else if (link.addr == A_TMR_LO) begin
        rdata_reg <= tmr_reg[7:0];
      end else if (link.addr == A_UPDATE) begin
        rdata_reg <= update_reg;
      end else begin
        rdata_reg <= 8'h00;
      end
    end
  end
  assign link.rdata = rdata_reg;
endmodule

// ==== verilog/clk_ctl_host.sv ====
// System controller for the clock distribution device: runs bring-up,
// shutdown, resync and pulse programs ordered over AHB-Lite.
// Assumes the device shares CLK_I; the valid pin is treated as async.
`timescale 1ns/1ps
// Notes on behaviour
// - Release device reset before any programming
// - Load configuration update values first
// - Program reference timer and pulse count next
// - Program every channel before the restart
// - Restart: write restart one then zero
// - Reseed request aligns divider phases
// - Wait six timer periods after sync
// - Phase status must read one before proceeding
// - Valid flag at address 7D bit 2
// - Valid flag may drive the output pin
// - Pulse request sends chains on pulse channels
// - Shutdown clears enables after receivers ignore
// - Resync sets enable and sync bits first
// - Sync-masked channels keep running untouched
// - Reseed then software re-enables receivers
// - Wait twenty periods before pulse request
// - Channel pairs share one retimed sync
// - Timer is submultiple, at most 4 MHz; the testbench runs it at 5 MHz (4 cycles of a 50 ns clock)
module clk_ctl_host (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  output logic IRQ_O,
  clk_link_if.ctl link
);
  import clk_pkg::*;
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_EXEC = 2'b01,
    S_WAIT = 2'b10,
    S_POLL = 2'b11
  } state_t;
  typedef enum logic [1:0] {
    OP_BRING = 2'b00,
    OP_SHUT = 2'b01,
    OP_RESYNC = 2'b10,
    OP_PULSE = 2'b11
  } op_t;
  state_t state_reg;
  op_t op_reg;
  logic [4:0] idx_reg;
  logic [19:0] cnt_reg;
  logic [31:0] cfg_reg, irq_mask_reg;
  logic [7:0] pcnt_reg;
  logic [1:0] irq_st_reg, irq_ev;
  logic err_reg, ap_wr_reg, ap_en_reg;
  logic [7:0] ap_addr_reg;
  logic gpo_m_reg, gpo_reg;
  logic [3:0] cmd;
  logic [11:0] per;
  step_t st;

  // Channel config byte: enable, sync enable, pulse mode, divide
  function automatic logic [7:0] ch_byte(logic [31:0] c, int i, logic en);
    ch_byte = {c[31:28], 1'b0, c[20+i], c[16+i], en & c[12+i]};
  endfunction

  // Program table; sequence order is the bring-up order
  function automatic step_t step_f(op_t op, logic [4:0] i, logic [31:0] c,
                                   logic [7:0] pc);
    step_f = '{K_END, 8'h00, 8'h00};
    case (op)
      OP_BRING: begin
        case (i)
          5'd0: step_f = '{K_RST, 8'h00, 8'h00};
          5'd1: step_f = '{K_WR, A_UPDATE, UPDATE_VAL};
          5'd2: step_f = '{K_WR, A_TMR_LO, c[7:0]};
          5'd3: step_f = '{K_WR, A_TMR_HI, {4'h0, c[11:8]}};
          5'd4: step_f = '{K_WR, A_PULSE_CNT, pc};
          5'd5: step_f = '{K_WR, A_GPO_SEL, 8'h01};
          5'd6, 5'd7, 5'd8, 5'd9: begin
            step_f = '{K_WR, A_CH_BASE + {6'h00, i[1:0] - 2'd2},
                       ch_byte(c, int'(i[1:0] - 2'd2), 1'b1)};
          end
          5'd10: step_f = '{K_WR, A_GLOBAL, 8'h02};
          5'd11: step_f = '{K_WR, A_GLOBAL, 8'h00};
          5'd12: step_f = '{K_WAIT, 8'h00, {3'h0, CAL_TICKS}};
          5'd13: step_f = '{K_WR, A_GLOBAL, 8'h01};
          5'd14: step_f = '{K_WR, A_GLOBAL, 8'h00};
          5'd15: step_f = '{K_WAIT, 8'h00, {3'h0, PHASE_TICKS}};
          5'd16: step_f = '{K_POLL, A_STATUS, 8'h00};
          default: step_f = '{K_END, 8'h00, 8'h00};
        endcase
      end
      OP_SHUT, OP_RESYNC: begin
        if (i < 5'd4) begin
          step_f = '{K_WR, A_CH_BASE + {6'h00, i[1:0]},
                     ch_byte(c, int'(i[1:0]), op == OP_RESYNC)};
        end else if (op == OP_RESYNC) begin
          case (i)
            5'd4: step_f = '{K_WR, A_GLOBAL, 8'h01};
            5'd5: step_f = '{K_WR, A_GLOBAL, 8'h00};
            5'd6: step_f = '{K_WAIT, 8'h00, {3'h0, PHASE_TICKS}};
            5'd7: step_f = '{K_POLL, A_STATUS, 8'h00};
            5'd8: begin
              if (c[23:20] != 4'h0) begin
                step_f = '{K_WAIT, 8'h00,
                           {3'h0, PULSE_GAP_TICKS - PHASE_TICKS}};
              end
            end
            5'd9: begin
              if (c[23:20] != 4'h0) step_f = '{K_WR, A_GLOBAL, 8'h04};
            end
            5'd10: step_f = '{K_WR, A_GLOBAL, 8'h00};
            default: step_f = '{K_END, 8'h00, 8'h00};
          endcase
        end
      end
      OP_PULSE: begin
        if (i == 5'd0) step_f = '{K_WR, A_GLOBAL, 8'h04};
        else if (i == 5'd1) step_f = '{K_WR, A_GLOBAL, 8'h00};
      end
      default: step_f = '{K_END, 8'h00, 8'h00};
    endcase
  endfunction

  assign st = step_f(op_reg, idx_reg, cfg_reg, pcnt_reg);
  assign per = (cfg_reg[11:0] == 12'h000) ? 12'h001 : cfg_reg[11:0];
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O = 1'b0;
  assign IRQ_O = |(irq_st_reg & irq_mask_reg[1:0]);

  // Valid pin from the device, resynchronised
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      gpo_m_reg <= 1'b0;
      gpo_reg <= 1'b0;
    end else begin
      gpo_m_reg <= link.general_output_pin;
      gpo_reg <= gpo_m_reg;
    end
  end

  // AHB-Lite address phase capture and read data
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ap_en_reg <= 1'b0;
      ap_wr_reg <= 1'b0;
      ap_addr_reg <= 8'h00;
      HRDATA_O <= 32'h00000000;
    end else begin
      ap_en_reg <= HSEL_I & HTRANS_I[1] & HREADY_I;
      ap_wr_reg <= HWRITE_I;
      ap_addr_reg <= HADDR_I[7:0];
      if (HADDR_I[7:0] == R_CFG) begin
        HRDATA_O <= cfg_reg;
      end else if (HADDR_I[7:0] == R_PULSE) begin
        HRDATA_O <= {24'h000000, pcnt_reg};
      end else if (HADDR_I[7:0] == R_STATUS) begin
        HRDATA_O <= {29'h0, gpo_reg, err_reg, state_reg != S_IDLE};
      end else if (HADDR_I[7:0] == R_IRQ_ST) begin
        HRDATA_O <= {30'h0, irq_st_reg};
      end else if (HADDR_I[7:0] == R_IRQ_MASK) begin
        HRDATA_O <= irq_mask_reg;
      end else begin
        HRDATA_O <= 32'h00000000;
      end
    end
  end

  // Commands; ignored while a program runs
  assign cmd = (ap_en_reg && ap_wr_reg && ap_addr_reg == R_CTRL &&
                state_reg == S_IDLE) ? HWDATA_I[3:0] : 4'h0;

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      cfg_reg <= CFG_RST;
      pcnt_reg <= PCNT_RST;
      irq_mask_reg <= 32'h00000000;
      irq_st_reg <= 2'b00;
    end else begin
      if (ap_en_reg && ap_wr_reg) begin
        if (ap_addr_reg == R_CFG) begin
          cfg_reg <= HWDATA_I;
        end else if (ap_addr_reg == R_PULSE) begin
          pcnt_reg <= HWDATA_I[7:0];
        end else if (ap_addr_reg == R_IRQ_MASK) begin
          irq_mask_reg <= {30'h0, HWDATA_I[1:0]};
        end
      end
      // Set wins over a write-one clear in the same cycle
      if (ap_en_reg && ap_wr_reg && ap_addr_reg == R_IRQ_ST) begin
        irq_st_reg <= (irq_st_reg & ~HWDATA_I[1:0]) | irq_ev;
      end else begin
        irq_st_reg <= irq_st_reg | irq_ev;
      end
    end
  end

  // Program sequencer
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_reg <= S_IDLE;
      op_reg <= OP_BRING;
      idx_reg <= 5'd0;
      cnt_reg <= 20'h00000;
      err_reg <= 1'b0;
      irq_ev <= 2'b00;
      link.dev_rst <= 1'b1;
      link.wr <= 1'b0;
      link.addr <= 8'h00;
      link.wdata <= 8'h00;
    end else begin
      link.wr <= 1'b0;
      irq_ev <= 2'b00;
      case (state_reg)
        S_IDLE: begin
          idx_reg <= 5'd0;
          if (cmd != 4'h0) begin
            state_reg <= S_EXEC;
            err_reg <= 1'b0;
            if (cmd[0]) op_reg <= OP_BRING;
            else if (cmd[1]) op_reg <= OP_SHUT;
            else if (cmd[2]) op_reg <= OP_RESYNC;
            else op_reg <= OP_PULSE;
          end
        end
        S_EXEC: begin
          link.addr <= st.addr;
          link.wdata <= st.data;
          idx_reg <= idx_reg + 5'd1;
          case (st.kind)
            K_WR: link.wr <= 1'b1;
            K_RST: begin
              link.dev_rst <= 1'b1;
              cnt_reg <= RST_HOLD;
              state_reg <= S_WAIT;
            end
            K_WAIT: begin
              cnt_reg <= 20'(st.data[4:0]) * 20'(per);
              state_reg <= S_WAIT;
            end
            K_POLL: begin
              cnt_reg <= POLL_TIMEOUT;
              state_reg <= S_POLL;
            end
            default: begin
              irq_ev <= 2'b01;
              state_reg <= S_IDLE;
            end
          endcase
        end
        S_WAIT: begin
          if (cnt_reg == 20'h00000) begin
            link.dev_rst <= 1'b0;
            state_reg <= S_EXEC;
          end else begin
            cnt_reg <= cnt_reg - 20'h00001;
          end
        end
        S_POLL: begin
          // Three poll cycles skipped for read latency before the status is trusted
          if (cnt_reg < POLL_TIMEOUT - 20'h00002 && link.rdata[ST_PHASE]) begin
            state_reg <= S_EXEC;
          end else if (cnt_reg == 20'h00000) begin
            err_reg <= 1'b1;
            irq_ev <= 2'b10;
            state_reg <= S_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 20'h00001;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end
endmodule

// ==== tb/clk_link_chk.sv ====
// Checker on the control link: write order, strobes, status timing.
// Assumes one clock for both ends and a timer period of TICK cycles.
`timescale 1ns/1ps
module clk_link_chk
  import clk_pkg::*;
#(
  parameter int TICK = 4
) (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic dev_rst,
  input wire logic wr,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic general_output_pin
);
  logic any_seen, tmr_seen, cnt_seen, rst_seen;
  logic [3:0] ch_seen;
  logic [15:0] since_seed;
  logic glob_wr, ch_wr;
  assign glob_wr = wr && addr == A_GLOBAL;
  assign ch_wr = wr && addr >= A_CH_BASE && addr < A_CH_BASE + 8'(NCH);

  // Order flags start over with every device reset
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I || dev_rst) begin
      any_seen <= 1'h0;
      tmr_seen <= 1'h0;
      cnt_seen <= 1'h0;
      rst_seen <= 1'h0;
      ch_seen <= 4'h0;
    end else begin
      any_seen <= any_seen | wr;
      tmr_seen <= tmr_seen | (wr && addr == A_TMR_HI);
      cnt_seen <= cnt_seen | (wr && addr == A_PULSE_CNT);
      rst_seen <= rst_seen | (glob_wr && wdata[G_RESTART]);
      if (ch_wr) begin
        ch_seen[addr[1:0]] <= 1'h1;
      end
    end
  end

  // Saturates so an old reseed never looks recent
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      since_seed <= 16'hFFFF;
    end else if (glob_wr && wdata[G_RESEED]) begin
      since_seed <= 16'h0000;
    end else if (since_seed != 16'hFFFF) begin
      since_seed <= since_seed + 16'h0001;
    end
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  sequence s_go;
    glob_wr && wdata != 8'h00;
  endsequence
  sequence s_release;
    glob_wr && wdata == 8'h00;
  endsequence

  a_rst_no_write: assert property (dev_rst |-> !wr)
    else $error("write while device held in reset");
  a_update_first: assert property (wr && !any_seen |->
    addr == A_UPDATE && wdata == UPDATE_VAL)
    else $error("first write is not the update load");
  a_tmr_before_ch: assert property (ch_wr |-> tmr_seen && cnt_seen)
    else $error("channel written before timer and count");
  a_ch_before_go: assert property (glob_wr && wdata[G_RESTART] |->
    ch_seen == 4'hF)
    else $error("restart before all channels written");
  a_go_released: assert property (s_go |=> s_release)
    else $error("control bit not returned to zero");
  a_seed_after_go: assert property (glob_wr && wdata[G_RESEED] |->
    rst_seen)
    else $error("reseed without earlier restart");
  a_poll_after_wait: assert property (addr == A_STATUS |->
    since_seed >= 16'(5 * TICK))
    else $error("status polled too soon after reseed");
  a_pulse_gap: assert property (glob_wr && wdata[G_PULSE] |->
    since_seed >= 16'(19 * TICK))
    else $error("pulse request too soon after reseed");
  a_gpo_after_seed: assert property ($rose(general_output_pin) |->
    since_seed >= 16'(5 * TICK))
    else $error("valid pin rose too soon after reseed");
  a_valid_has_phase: assert property ($past(addr) == A_STATUS &&
    rdata[ST_VALID] |-> rdata[ST_PHASE])
    else $error("valid flag without phases reached");
  a_gpo_quiet_rst: assert property (dev_rst [*3] |-> !general_output_pin)
    else $error("valid pin high during device reset");
endmodule

// ==== tb/tb.sv ====
// Testbench: controller and device joined by the link, driven over AHB.
// Assumes zero-wait slave timing is not relied on; all waits are bounded.
`timescale 1ns/1ps
module tb;
  import clk_pkg::*;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic input_clock_pin_ok = 1'h1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, q;
  logic hready, hresp, irq, ref_valid;
  logic [NCH-1:0] ch_out;
  int fails = 0;
  int checked = 0;
  clk_link_if link();
  always #25 clk = ~clk;
  clk_dist_dev clk_dist_dev_i(.CLK_I(clk), .RST_I(rst),
    .INPUT_CLOCK_PIN_OK_I(input_clock_pin_ok), .link(link), .CH_OUT_O(ch_out),
    .REF_VALID_O(ref_valid));
  clk_ctl_host clk_ctl_host_i(.CLK_I(clk), .RST_I(rst), .HSEL_I(1'h1),
    .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
    .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
    .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
    .IRQ_O(irq), .link(link));
  clk_link_chk #(.TICK(4)) clk_link_chk_i(.CLK_I(clk), .RST_I(rst),
    .dev_rst(link.dev_rst), .wr(link.wr), .addr(link.addr),
    .wdata(link.wdata), .rdata(link.rdata), .general_output_pin(link.general_output_pin));

  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wait_ready;
    int n;
    n = 0;
    @(posedge clk);
    while (hready !== 1'h1) begin
      n++;
      if (n > 100) begin
        fails++;
        tally_and_finish();
      end
      @(posedge clk);
    end
  endtask

  // Address phase held until ready, then data phase until ready
  task automatic ahb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'h1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    ahb(1'h0, a, 32'h0);
  endtask

  // Long enough to outlast the controller's own poll timeout
  task automatic idle;
    int n;
    n = 0;
    // Read data is loaded at the command's own edge, so skip one cycle
    @(posedge clk);
    rd(R_STATUS);
    while (q[0] !== 1'h0) begin
      n++;
      if (n > 5000) begin
        fails++;
        tally_and_finish();
      end
      rd(R_STATUS);
    end
  endtask

  task automatic t_regs;
    rd(R_CFG);
    check("cfg reset", q, CFG_RST);
    rd(R_PULSE);
    check("pulse reset", q, 32'h00000004);
    rd(R_CTRL);
    check("ctrl read", q, 32'h0);
    rd(8'h40);
    check("unmapped read", q, 32'h0);
    wr(R_IRQ_MASK, 32'hFFFFFFFF);
    rd(R_IRQ_MASK);
    check("mask width", q, 32'h00000003);
  endtask

  task automatic t_bringup;
    wr(R_CTRL, 32'h1);
    idle();
    check("bringup status", q, 32'h00000004);
    @(negedge clk);
    check("valid out", {31'h0, ref_valid}, 32'h1);
    check("valid pin", {31'h0, link.general_output_pin}, 32'h1);
    check("irq done", {31'h0, irq}, 32'h1);
    @(posedge clk);
    rd(R_IRQ_ST);
    check("irq status", q, 32'h1);
    wr(R_IRQ_ST, 32'h1);
    @(negedge clk);
    check("irq cleared", {31'h0, irq}, 32'h0);
    @(posedge clk);
  endtask

  task automatic t_no_clock;
    input_clock_pin_ok <= 1'h0;
    wr(R_CTRL, 32'h1);
    idle();
    check("synced without clock", {31'h0, q[2]}, 32'h0);
    check("poll timeout flag", {31'h0, q[1]}, 32'h1);
    @(negedge clk);
    check("valid without clock", {31'h0, ref_valid}, 32'h0);
    check("pin without clock", {31'h0, link.general_output_pin}, 32'h0);
    @(posedge clk);
    input_clock_pin_ok <= 1'h1;
    wr(R_IRQ_ST, 32'h3);
    t_bringup();
  endtask

  task automatic t_irq_mask;
    repeat (100) @(posedge clk);
    wr(R_IRQ_MASK, 32'h0);
    wr(R_CTRL, 32'h8);
    idle();
    @(negedge clk);
    check("masked irq", {31'h0, irq}, 32'h0);
    @(posedge clk);
    rd(R_IRQ_ST);
    check("pulse done", q, 32'h1);
    wr(R_IRQ_MASK, 32'h3);
    @(negedge clk);
    check("unmasked irq", {31'h0, irq}, 32'h1);
    @(posedge clk);
    wr(R_IRQ_ST, 32'h1);
  endtask

  // Only channel 0 takes the sync; the others must ride through it
  task automatic t_resync;
    int hi;
    int flips;
    logic last;
    wr(R_CFG, 32'h1011F004);
    wr(R_CTRL, 32'h4);
    idle();
    check("resync status", q, 32'h00000004);
    rd(R_IRQ_ST);
    check("resync done", q, 32'h1);
    wr(R_IRQ_ST, 32'h1);
    hi = 0;
    flips = 0;
    last = ch_out[1];
    repeat (80) begin
      @(negedge clk);
      hi += ch_out[0];
      flips += (ch_out[1] != last);
      last = ch_out[1];
    end
    @(posedge clk);
    check("pulse chain seen", {31'h0, hi != 0}, 32'h1);
    check("masked channel runs", {31'h0, flips != 0}, 32'h1);
  endtask

  task automatic t_shutdown;
    wr(R_CTRL, 32'h2);
    idle();
    repeat (20) @(posedge clk);
    @(negedge clk);
    check("outputs off", {28'h0, ch_out}, 32'h0);
    @(posedge clk);
  endtask

  task automatic t_mid_reset;
    wr(R_CTRL, 32'h1);
    repeat (3) @(posedge clk);
    rst <= 1'h1;
    @(negedge clk);
    check("dev reset held", {31'h0, link.dev_rst}, 32'h1);
    check("no strobe", {31'h0, link.wr}, 32'h0);
    check("irq in reset", {31'h0, irq}, 32'h0);
    @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    rd(R_CFG);
    check("cfg after reset", q, CFG_RST);
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    t_regs();
    t_bringup();
    t_no_clock();
    t_irq_mask();
    t_resync();
    t_shutdown();
    t_mid_reset();
    tally_and_finish();
  end
endmodule
